/* shared/tmr_pkg.sv */
// constants and types shared by the timer, counter and dead-band block
// Operation
// - timer mode decrements the count on each source clock rising edge while carry-in is high
// - timer reloads count from period when enabled and after reaching zero
// - any timer capture copies the count into the compare/capture register
// - a processor read of the count in timer mode is a capture
// - rising capture input is synchronised and triggers a capture; the code edge-detects the raw input with no synchroniser
// - terminal-count output is high while the count equals zero and carry-in is high
// - interrupt select picks terminal-count rise or compare rise in timer
// - compare operator select picks less-than or less-or-equal
// - blocks chain through carry signals, eight bits per block
// - counter mode reloads count from period after reaching zero
// - counter decrements on source rising edge only while enable is high
// - counter compare output updates on source falling edge
// - counter compare interrupt fires once, rearmed by the next reload
// - dead-band phases follow the input and are never high together
// - input rise: complementary low, count down, then primary high
// - input fall: primary low, same dead time, then complementary high
// - dead-band counter is eight bits and does not chain
// - dead-band loads count from period when enabled and at terminal
// - dead time is source period times one plus period value
// - control bit 0 enables the function and resets to zero
package tmr_pkg;

   // register byte offsets on the bus
   localparam logic [7:0] OFS_COUNT   = 8'h00;
   localparam logic [7:0] OFS_PERIOD  = 8'h04;
   localparam logic [7:0] OFS_COMPARE = 8'h08;
   localparam logic [7:0] OFS_CONTROL = 8'h0c;
   localparam logic [7:0] OFS_FUNC    = 8'h10;

   // field positions
   localparam int CTL_ENABLE_BIT = 0;
   localparam int FN_SEL_LSB     = 0;
   localparam int FN_IRQSEL_BIT  = 2;
   localparam int FN_LESEQ_BIT   = 3;

   // reset values
   localparam logic [7:0] RST_DATA = 8'h00;
   localparam logic       RST_BIT  = 1'b0;

   // data width of one block
   localparam int BLOCK_W = 8;

   typedef enum logic [1:0] {
      FN_TIMER    = 2'b00,
      FN_COUNTER  = 2'b01,
      FN_DEADBAND = 2'b10,
      FN_SPARE    = 2'b11
   } func_t;

   typedef enum logic [2:0] {
      DB_IDLE      = 3'b000,
      DB_DEAD_RISE = 3'b001,
      DB_HIGH_PRI  = 3'b010,
      DB_DEAD_FALL = 3'b011,
      DB_HIGH_CMP  = 3'b100
   } db_state_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } apb_rsp_t;

   typedef struct packed {
      logic tc;       // terminal count
      logic cmp;      // compare / pulse-width
      logic irq;      // one-cycle interrupt pulse
      logic pri;      // dead-band primary phase
      logic cmpl;     // dead-band complementary phase
      logic carry;    // chain carry to the next block
   } blk_out_t;

endpackage

/* core/edge_detect.sv */
// registers input levels and flags their rising and falling edges
`timescale 1ns/1ps
module edge_detect #(
   parameter int W = 3
) (
   input  wire logic         clk_sys_i, // system clock
   input  wire logic         rst_n_i,   // async reset, active low
   input  wire logic [W-1:0] level_i,   // sampled levels
   output logic      [W-1:0] rise_o,    // level went 0 to 1
   output logic      [W-1:0] fall_o     // level went 1 to 0
);
   typedef struct packed {
      logic [W-1:0] prev;
   } edge_state_t;

   edge_state_t st_reg;
   edge_state_t st_next;

   generate
      if (W < 1) begin : g_chk
         $error("edge_detect needs W of at least one");
      end
   endgenerate

   // previous level follows the input
   always_comb begin
      st_next      = st_reg;
      st_next.prev = level_i;
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // edges against the previous cycle
   assign rise_o = level_i & ~st_reg.prev;
   assign fall_o = ~level_i & st_reg.prev;
endmodule

/* core/tmr_block.sv */
// timer, counter and dead-band function block with an apb register slave
`timescale 1ns/1ps
module tmr_block #(
   parameter int CNT_W = 8
) (
   input  wire logic              clk_sys_i, // system clock, 100 MHz
   input  wire logic              rst_n_i,   // async reset, active low
   input  wire tmr_pkg::apb_req_t apb_i,     // apb request
   output tmr_pkg::apb_rsp_t      apb_o,     // apb answer
   input  wire logic              src_clk_i, // selected source clock level
   input  wire logic              data_i,    // capture / enable / waveform
   input  wire logic              carry_i,   // chain carry from lower block
   output tmr_pkg::blk_out_t      blk_o      // block outputs
);
   import tmr_pkg::*;

   typedef struct packed {
      apb_rsp_t    rsp;
      logic [7:0]  count;
      logic [7:0]  period;
      logic [7:0]  compare;
      logic        enable;
      func_t       func;
      logic        irq_sel;
      logic        le_sel;
      logic        cmp_flag;
      logic        armed;
      db_state_t   db;
      blk_out_t    outs;
   } blk_state_t;

   blk_state_t st_reg;
   blk_state_t st_next;

   logic [2:0] rise;
   logic [2:0] fall;

   generate
      if (CNT_W != BLOCK_W) begin : g_chk
         $error("tmr_block serves only eight-bit count width");
      end
   endgenerate

   // chosen compare relation between count and compare register
   function automatic logic cmp_hit(input logic [7:0] cnt,
                                    input logic [7:0] ref_v,
                                    input logic       le);
      cmp_hit = le ? (cnt <= ref_v) : (cnt < ref_v);
   endfunction

   // register decode shared by read and write
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == OFS_COUNT) || (a == OFS_PERIOD) ||
               (a == OFS_COMPARE) || (a == OFS_CONTROL) ||
               (a == OFS_FUNC);
   endfunction

   // edges of source clock, data input and carry-in
   edge_detect #(
      .W (3)
   ) u_edges (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .level_i   ({carry_i, data_i, src_clk_i}),
      .rise_o    (rise),
      .fall_o    (fall)
   );

   logic src_rise;
   logic src_fall;
   logic dat_rise;
   logic dat_fall;
   assign src_rise = rise[0];
   assign src_fall = fall[0];
   assign dat_rise = rise[1];
   assign dat_fall = fall[1];

   // bus handshake, register access and the three functions
   always_comb begin
      logic       done;
      logic       wr;
      logic       rd;
      logic       tick;
      logic       at_zero;
      logic       new_cmp;
      logic       capture;
      logic [7:0] rdat;
      done    = 1'b0;
      wr      = 1'b0;
      rd      = 1'b0;
      tick    = 1'b0;
      at_zero = 1'b0;
      new_cmp = 1'b0;
      capture = 1'b0;
      rdat    = 8'h00;
      st_next = st_reg;

      // apb: one wait state, answer raised on the second access cycle
      done = apb_i.psel & apb_i.penable & st_reg.rsp.pready;
      wr   = done & apb_i.pwrite & mapped(apb_i.paddr);
      rd   = done & ~apb_i.pwrite;
      st_next.rsp.pready  = apb_i.psel & apb_i.penable &
                            ~st_reg.rsp.pready;
      st_next.rsp.pslverr = apb_i.psel & apb_i.penable &
                            ~st_reg.rsp.pready & ~mapped(apb_i.paddr);
      unique case (apb_i.paddr)
         OFS_COUNT:   rdat = st_reg.count;
         OFS_PERIOD:  rdat = st_reg.period;
         OFS_COMPARE: rdat = st_reg.compare;
         OFS_CONTROL: rdat = {7'h00, st_reg.enable};
         OFS_FUNC:    rdat = {4'h0, st_reg.le_sel, st_reg.irq_sel,
                              st_reg.func};
         default:     rdat = 8'h00;
      endcase
      if (apb_i.psel & apb_i.penable & ~st_reg.rsp.pready) begin
         st_next.rsp.prdata = {24'h000000, rdat};
      end
      if (done) begin
         st_next.rsp.prdata = 32'h00000000;
      end

      // register writes
      if (wr) begin
         unique case (apb_i.paddr)
            OFS_PERIOD:  st_next.period  = apb_i.pwdata[7:0];
            OFS_COMPARE: st_next.compare = apb_i.pwdata[7:0];
            OFS_CONTROL: begin
               st_next.enable = apb_i.pwdata[CTL_ENABLE_BIT];
               if (apb_i.pwdata[CTL_ENABLE_BIT] & ~st_reg.enable) begin
                  st_next.count = st_reg.period;
                  st_next.armed = 1'b1;
                  st_next.db    = DB_IDLE;
               end
            end
            OFS_FUNC: begin
               st_next.func    = func_t'(apb_i.pwdata[FN_SEL_LSB +: 2]);
               st_next.irq_sel = apb_i.pwdata[FN_IRQSEL_BIT];
               st_next.le_sel  = apb_i.pwdata[FN_LESEQ_BIT];
            end
            default: st_next.count = st_reg.count;
         endcase
      end

      st_next.outs = '0;
      at_zero = (st_reg.count == 8'h00);

      // disabled: count held, every output low
      if (!st_reg.enable) begin
         st_next.outs = '0;
      end else begin
         unique case (st_reg.func)
            FN_TIMER: begin
               // count only when the lower chained block carries
               tick = src_rise & carry_i;
               if (tick) begin
                  if (at_zero) begin
                     st_next.count = st_reg.period;
                  end else begin
                     st_next.count = st_reg.count - 8'h01;
                  end
               end
               // hardware capture on data rise, software on count read
               capture = dat_rise |
                         (rd & (apb_i.paddr == OFS_COUNT));
               if (capture) begin
                  st_next.compare = st_reg.count;
               end
               st_next.outs.tc = (st_next.count == 8'h00) & carry_i;
               st_next.outs.carry = st_next.outs.tc;
               new_cmp = cmp_hit(st_next.count, st_next.compare,
                                 st_reg.le_sel);
               st_next.cmp_flag = new_cmp;
               if (st_reg.irq_sel) begin
                  st_next.outs.irq = new_cmp & ~st_reg.cmp_flag;
               end else begin
                  // terminal-count rise selected as the source
                  st_next.outs.irq = st_next.outs.tc & ~st_reg.outs.tc;
               end
            end
            FN_COUNTER: begin
               // gated by the enable input and the chain carry
               tick = src_rise & data_i & carry_i;
               if (tick) begin
                  if (at_zero) begin
                     st_next.count = st_reg.period;
                     st_next.armed = 1'b1;
                  end else begin
                     st_next.count = st_reg.count - 8'h01;
                  end
               end
               // compare output moves only on source falling edge
               st_next.cmp_flag = st_reg.cmp_flag;
               if (src_fall) begin
                  st_next.cmp_flag = cmp_hit(st_reg.count, st_reg.compare,
                                             st_reg.le_sel);
               end
               st_next.outs.cmp = st_next.cmp_flag;
               st_next.outs.tc = (st_next.count == 8'h00) & carry_i;
               st_next.outs.carry = st_next.outs.tc;
               if (st_reg.irq_sel) begin
                  if (st_next.cmp_flag & ~st_reg.cmp_flag &
                      st_next.armed) begin
                     st_next.outs.irq = 1'b1;
                     st_next.armed    = 1'b0;
                  end
               end else begin
                  st_next.outs.irq = st_next.outs.tc & ~st_reg.outs.tc;
               end
            end
            FN_DEADBAND: begin
               // phases kept from the previous cycle unless changed below
               st_next.outs.pri  = st_reg.outs.pri;
               st_next.outs.cmpl = st_reg.outs.cmpl;
               if (dat_rise) begin
                  st_next.outs.cmpl = 1'b0;
                  st_next.count     = st_reg.period;
                  st_next.db        = DB_DEAD_RISE;
               end else if (dat_fall) begin
                  st_next.outs.pri = 1'b0;
                  st_next.count    = st_reg.period;
                  st_next.db       = DB_DEAD_FALL;
               end else if (src_rise &&
                            (st_reg.db == DB_DEAD_RISE ||
                             st_reg.db == DB_DEAD_FALL)) begin
                  // period+1 source ticks of dead time, no chaining
                  if (at_zero) begin
                     st_next.count = st_reg.period;
                     if (st_reg.db == DB_DEAD_RISE) begin
                        st_next.outs.pri = 1'b1;
                        st_next.db       = DB_HIGH_PRI;
                     end else begin
                        st_next.outs.cmpl = 1'b1;
                        st_next.db        = DB_HIGH_CMP;
                     end
                  end else begin
                     st_next.count = st_reg.count - 8'h01;
                  end
               end
               // never both high
               if (st_next.outs.pri) begin
                  st_next.outs.cmpl = 1'b0;
               end
            end
            default: st_next.outs = '0;
         endcase
      end
   end

   // state register
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_reg          <= '0;
         st_reg.count    <= RST_DATA;
         st_reg.period   <= RST_DATA;
         st_reg.compare  <= RST_DATA;
         st_reg.enable   <= RST_BIT;
         st_reg.func     <= FN_TIMER;
         st_reg.db       <= DB_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   // every output straight from the state register
   assign apb_o = st_reg.rsp;
   assign blk_o = st_reg.outs;
endmodule

/* tb/tmr_block_monitor.sv */
// port-level checker for the timer, counter and dead-band block
`timescale 1ns/1ps
module tmr_block_monitor #(
   parameter int CNT_W = 8
) (
   input wire logic              clk_sys_i, // system clock
   input wire logic              rst_n_i,   // async reset, active low
   input wire tmr_pkg::apb_req_t apb_i,     // apb request
   input wire tmr_pkg::apb_rsp_t apb_o,     // apb answer
   input wire logic              src_clk_i, // source clock level
   input wire logic              data_i,    // capture / enable / wave
   input wire logic              carry_i,   // chain carry in
   input wire tmr_pkg::blk_out_t blk_o      // block outputs
);
   import tmr_pkg::*;
   logic done_w;
   logic ctl_w;
   logic en_q;
   // completed write to the control register
   assign done_w = apb_i.psel && apb_i.penable && apb_o.pready;
   assign ctl_w  = done_w && apb_i.pwrite && apb_i.paddr == OFS_CONTROL;
   // mirror of the enable bit as software left it
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         en_q <= 1'b0;
      end else if (ctl_w) begin
         en_q <= apb_i.pwdata[CTL_ENABLE_BIT];
      end
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   // setup then first access cycle, answered after one wait state
   sequence s_setup;
      apb_i.psel && !apb_i.penable;
   endsequence
   sequence s_one_wait;
      !apb_o.pready ##1 apb_o.pready;
   endsequence
   a_access_wait: assert property (
      s_setup ##1 (apb_i.psel && apb_i.penable) |-> s_one_wait)
      else $error("ready not after one wait state");
   a_ready_single: assert property (apb_o.pready |=> !apb_o.pready)
      else $error("ready held past one cycle");
   a_rdata_idle: assert property (!apb_o.pready |-> apb_o.prdata == 32'h0)
      else $error("read data outside the ready cycle");
   a_err_ready: assert property (apb_o.pslverr |-> apb_o.pready)
      else $error("error flag without ready");
   a_off_quiet: assert property (
      !en_q && !$past(en_q) |-> blk_o == '0)
      else $error("outputs active while disabled");
   a_phase_apart: assert property (!(blk_o.pri && blk_o.cmpl))
      else $error("both phases high");
   a_rise_cmpl: assert property (
      $rose(data_i) |-> ##2 !blk_o.cmpl)
      else $error("complementary phase kept after input rise");
   a_fall_pri: assert property ($fell(data_i) |-> ##2 !blk_o.pri)
      else $error("primary phase kept after input fall");
   a_irq_single: assert property (blk_o.irq |=> !blk_o.irq)
      else $error("interrupt longer than one cycle");
   a_carry_tc: assert property (blk_o.carry |-> blk_o.tc)
      else $error("carry without terminal count");
   a_tc_carry: assert property (blk_o.tc |-> blk_o.carry)
      else $error("terminal count not passed down the chain");
endmodule

bind tmr_block tmr_block_monitor #(.CNT_W(CNT_W)) mon_i (
   .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .apb_i(apb_i),
   .apb_o(apb_o), .src_clk_i(src_clk_i), .data_i(data_i),
   .carry_i(carry_i), .blk_o(blk_o));

/* tb/src_fabric_model.sv */
// source clock model standing in for the routing fabric
`timescale 1ns/1ps
module src_fabric_model #(
   parameter int HALF = 3
) (
   input  wire logic clk_sys_i, // system clock
   input  wire logic rst_n_i,   // async reset, active low
   input  wire logic run_i,     // let the source clock toggle
   output logic      src_clk_o  // source clock to the block
);
   logic [3:0] cnt_reg;
   // toggles every HALF cycles, stands low while stopped
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_reg   <= 4'h0;
         src_clk_o <= 1'b0;
      end else if (!run_i) begin
         cnt_reg   <= 4'h0;
         src_clk_o <= 1'b0;
      end else if (cnt_reg == 4'(HALF - 1)) begin
         cnt_reg   <= 4'h0;
         src_clk_o <= ~src_clk_o; // fixed source period
      end else begin
         cnt_reg <= cnt_reg + 4'h1;
      end
   end
endmodule

/* tb/tmr_block_tb_top.sv */
// self-checking bench for the timer, counter and dead-band block
`timescale 1ns/1ps
module tmr_block_tb_top;
   import tmr_pkg::*;
   logic     clk_sys_i = 1'b0;
   logic     rst_n_i   = 1'b0;
   apb_req_t apb_req   = '0;
   apb_rsp_t apb_rsp;
   blk_out_t blk;
   logic     src_clk;
   logic     data_in   = 1'b0;
   logic     carry_in  = 1'b1;
   logic     run       = 1'b0;
   logic     tc_seen   = 1'b0;
   logic     cmp_seen  = 1'b0;
   int       irq_n     = 0;
   int       bad_count = 0;
   int       n_checks  = 0;

   always #5 clk_sys_i = ~clk_sys_i;

   tmr_block #(.CNT_W(8)) DUT (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .apb_i(apb_req),
      .apb_o(apb_rsp), .src_clk_i(src_clk), .data_i(data_in),
      .carry_i(carry_in), .blk_o(blk));
   src_fabric_model #(.HALF(3)) fabric (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .run_i(run),
      .src_clk_o(src_clk));

   // note output activity at each edge
   always @(posedge clk_sys_i) begin
      if (blk.irq === 1'b1) irq_n++;
      if (blk.tc === 1'b1) tc_seen = 1'b1;
      if (blk.cmp === 1'b1) cmp_seen = 1'b1;
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one apb transfer, held until ready is sampled high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      int n;
      apb_req.psel    <= 1'b1;
      apb_req.penable <= 1'b0;
      apb_req.pwrite  <= w;
      apb_req.paddr   <= a;
      apb_req.pwdata  <= d;
      @(posedge clk_sys_i);
      apb_req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (apb_rsp.pready !== 1'b1 && n < 50);
      q = apb_rsp.prdata;
      e = apb_rsp.pslverr;
      apb_req.psel    <= 1'b0;
      apb_req.penable <= 1'b0;
      if (n >= 50) begin bad_count++; conclude(); end
      @(posedge clk_sys_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, {24'h0, d}, q, e);
   endtask

   task automatic rd(input string nm, input logic [7:0] a,
                     input logic [31:0] exp);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      check(nm, q, exp);
   endtask

   // run the source for n rises or until a phase output goes high
   task automatic run_src(input int n, input int ph, output int k);
      int   w;
      logic prev;
      k = 0;
      prev = src_clk;
      run <= 1'b1;
      for (w = 0; w < 400 && k < n; w++) begin
         @(posedge clk_sys_i);
         if ((ph == 1 && blk.pri === 1'b1) ||
             (ph == 2 && blk.cmpl === 1'b1)) break;
         if (src_clk && !prev) k++;
         prev = src_clk;
      end
      run <= 1'b0;
      if (w >= 400) begin bad_count++; conclude(); end
      repeat (4) @(posedge clk_sys_i);
   endtask

   task automatic test_reset();
      logic [7:0]  ofs [5];
      logic [31:0] q;
      logic        e;
      ofs = '{OFS_COUNT, OFS_PERIOD, OFS_COMPARE, OFS_CONTROL, OFS_FUNC};
      foreach (ofs[i]) rd("reset value", ofs[i], 32'h0);
      apb(1'b0, 8'h14, 32'h0, q, e);
      check("unmapped error", {31'h0, e}, 32'h1);
      check("unmapped data", q, 32'h0);
   endtask

   task automatic test_timer();
      int k;
      wr(OFS_PERIOD, 8'h03);
      wr(OFS_CONTROL, 8'h01);
      rd("timer load", OFS_COUNT, 32'h3);
      rd("soft capture", OFS_COMPARE, 32'h3);
      irq_n = 0;
      run_src(5, 0, k);
      rd("timer count", OFS_COUNT, 32'h2);
      check("tc seen", {31'h0, tc_seen}, 32'h1);
      check("tc interrupt", 32'(irq_n), 32'h1);
      carry_in <= 1'b0;
      run_src(2, 0, k);
      rd("chain hold", OFS_COUNT, 32'h2);
      carry_in <= 1'b1;
      run_src(1, 0, k);
      data_in <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
      data_in <= 1'b0;
      rd("hw capture", OFS_COMPARE, 32'h1);
      wr(OFS_CONTROL, 8'h00);
   endtask

   task automatic test_counter();
      int k;
      int le;
      wr(OFS_FUNC, 8'h05);
      wr(OFS_PERIOD, 8'h04);
      wr(OFS_CONTROL, 8'h01);
      data_in <= 1'b1;
      run_src(2, 0, k);
      data_in <= 1'b0;
      run_src(3, 0, k);
      wr(OFS_CONTROL, 8'h00);
      rd("gated count", OFS_COUNT, 32'h2);
      wr(OFS_COMPARE, 8'h02);
      irq_n = 0;
      wr(OFS_CONTROL, 8'h01);
      data_in <= 1'b1;
      run_src(6, 0, k);
      wr(OFS_CONTROL, 8'h00);
      rd("counter reload", OFS_COUNT, 32'h3);
      check("one interrupt", 32'(irq_n), 32'h1);
      check("compare seen", {31'h0, cmp_seen}, 32'h1);
      // compare of zero only matches with less-or-equal
      for (le = 0; le < 2; le++) begin
         wr(OFS_FUNC, (le == 1) ? 8'h0d : 8'h05);
         wr(OFS_COMPARE, 8'h00);
         irq_n = 0;
         wr(OFS_CONTROL, 8'h01);
         run_src(5, 0, k);
         wr(OFS_CONTROL, 8'h00);
         check("compare operator", 32'(irq_n), 32'(le));
      end
      data_in <= 1'b0;
   endtask

   task automatic test_deadband();
      int k;
      wr(OFS_FUNC, 8'h02);
      wr(OFS_PERIOD, 8'h01);
      wr(OFS_CONTROL, 8'h01);
      data_in <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      run_src(99, 1, k);
      check("rise dead time", 32'(k), 32'h2);
      data_in <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      check("primary low", {31'h0, blk.pri}, 32'h0);
      run_src(99, 2, k);
      check("fall dead time", 32'(k), 32'h2);
      // a new rise must pull the high complementary phase down at once
      data_in <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      check("complementary low", {31'h0, blk.cmpl}, 32'h0);
      check("primary still low", {31'h0, blk.pri}, 32'h0);
      data_in <= 1'b0;
      wr(OFS_CONTROL, 8'h00);
      repeat (2) @(posedge clk_sys_i);
      check("disabled outputs", {26'h0, blk}, 32'h0);
   endtask

   initial begin
      repeat (6) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      @(posedge clk_sys_i);
      test_reset();
      test_timer();
      test_counter();
      test_deadband();
      conclude();
   end
endmodule
